// >>> design/bridge_pwm_map.svh
// Purpose: register offsets, field positions, reset values and counts
// Assumes: 8-bit registers behind a 4-bit register address
// Notes: definitions only
`ifndef BRIDGE_PWM_MAP_SVH
`define BRIDGE_PWM_MAP_SVH

// register offsets
`define BPW_OFF_DEL 4'h0
`define BPW_OFF_AS 4'h1
`define BPW_OFF_CTRL 4'h2
`define BPW_OFF_STAT 4'h3

// dead-band / restart register fields
`define BPW_RSEN_BIT 7
`define BPW_DC_HI 6
`define BPW_DC_LO 0

// auto-shutdown register fields
`define BPW_ASE_BIT 7
`define BPW_SRC_HI 6
`define BPW_SRC_LO 4
`define BPW_PSS_AC_HI 3
`define BPW_PSS_AC_LO 2
`define BPW_PSS_BD_HI 1
`define BPW_PSS_BD_LO 0

// control register fields
`define BPW_MODE_HI 1
`define BPW_MODE_LO 0
`define BPW_PRESC_HI 3
`define BPW_PRESC_LO 2

// reset values
`define BPW_DEL_RST 8'h00
`define BPW_AS_RST 8'h00
`define BPW_CTRL_RST 8'h00

// prescale select codes and their divide counts
`define BPW_PRESC_SEL_1 2'h0
`define BPW_PRESC_SEL_4 2'h1
`define BPW_PRESC_1 5'h01
`define BPW_PRESC_4 5'h04
`define BPW_PRESC_16 5'h10

// core clocks per instruction cycle (one instruction cycle is 4 Tosc)
`define BPW_TCY_CLKS_DEF 4

`endif

// >>> design/bridge_pwm_pkg.sv
// Purpose: shared types of the bridge steering and shutdown stage
// Assumes: nothing beyond SystemVerilog packages
// Notes: numbers live in bridge_pwm_map.svh
package bridge_pwm_pkg;

    // one register access from software
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // output configuration, order matches the two-bit mode field
    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_FULL_FWD,
        MODE_HALF,
        MODE_FULL_REV
    } out_mode_t;

endpackage

// >>> design/bridge_pwm_steering_shutdown.sv
// Purpose: steer a PWM signal onto four bridge outputs, dead-band, auto-shutdown
// Assumes: duty comparator and period timer live outside on the same clock
// Notes: comparator and fault inputs are asynchronous and are synchronised
//
// Notes on behaviour
// - forward: A active, D modulated, B C off
// - reverse: C active, B modulated, A D off
// - direction change takes effect next PWM cycle
// - lead interval: modulated off, unmodulated swapped early
// - prescale of 1, 4 or 16 by select
// - no dead-band in full-bridge modes
// - half-bridge dead-band only on rising transitions
// - seven-bit delay counted in instruction cycles
// - source select decodes comparators and fault pin
// - selected source forces shutdown states at once
// - pair states: low, high or tri-state
// - hardware sets shutdown flag on event
// - flag at period start holds whole period
// - restart enabled: flag clears when cause leaves
// - restart disabled: software must clear flag
// - flag writes ignored while cause active
// - comparator cause is a level, blocks clear
// - writing one forces shutdown
// - period boundary on increment after timer match
// - half-bridge: PWM on A, complement on B
//
// Added by the designer: the plain strobed port and the address map.
`include "bridge_pwm_map.svh"

module bridge_pwm_steering_shutdown
    import bridge_pwm_pkg::*;
#(
    parameter int TCY_CLKS = `BPW_TCY_CLKS_DEF
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire reg_req_t i_reg,
    output logic [7:0] o_rd_data,
    input wire logic i_pwm_mod,
    input wire logic i_timer_match,
    output logic o_timer_inc,
    input wire logic i_cmp1,
    input wire logic i_cmp2,
    input wire logic i_fault_input_pin,
    output logic [3:0] o_bridge_out,
    output logic [3:0] o_bridge_oe
);

    localparam int OUT_A = 0;
    localparam int OUT_B = 1;
    localparam int OUT_C = 2;
    localparam int OUT_D = 3;

    logic [7:0] dead_band_restart_ctrl_r;
    logic [7:0] auto_shutdown_config;
    logic shutdown_flag_r;
    logic [6:0] as_cfg_r;
    logic [7:0] ctrl_r;
    logic [7:0] rd_data_r;
    logic [2:0] src_meta_r;
    logic [2:0] src_sync_r;
    logic [1:0] tcy_cnt_r;
    logic [4:0] pre_cnt_r;
    logic [4:0] presc_len;
    logic timer_inc_r;
    logic instr_en;
    logic boundary;
    logic dir_cur_r;
    logic run_r;
    logic cause;
    logic hold;
    logic lead;
    logic full_mode;
    logic wr_as;
    logic [3:0] out_r;
    logic [3:0] oe_r;
    logic [3:0] out_nxt;
    logic [3:0] oe_nxt;
    logic [1:0] db_target;
    logic [1:0] db_ok;
    logic [6:0] db_cnt_r [2];
    out_mode_t mode;
    logic bridge_direction_bit;
    logic shutdown_status_bit;
    logic auto_restart_enable;
    logic [6:0] dead_delay_count;
    logic [2:0] shutdown_source_select;
    logic [1:0] pair_ac_shutdown_state;
    logic [1:0] pair_bd_shutdown_state;
    logic [1:0] period_timer_prescale_sel;

    // register fields
    assign mode = out_mode_t'(ctrl_r[`BPW_MODE_HI:`BPW_MODE_LO]);
    assign bridge_direction_bit = ctrl_r[`BPW_MODE_HI];
    assign period_timer_prescale_sel = ctrl_r[`BPW_PRESC_HI:`BPW_PRESC_LO];
    assign auto_restart_enable = dead_band_restart_ctrl_r[`BPW_RSEN_BIT];
    assign dead_delay_count = dead_band_restart_ctrl_r[`BPW_DC_HI:`BPW_DC_LO];
    // flag and plain fields live in separate flops, one writer each
    assign auto_shutdown_config = {shutdown_flag_r, as_cfg_r};
    assign shutdown_status_bit = auto_shutdown_config[`BPW_ASE_BIT];
    assign shutdown_source_select = auto_shutdown_config[`BPW_SRC_HI:`BPW_SRC_LO];
    assign pair_ac_shutdown_state = auto_shutdown_config[`BPW_PSS_AC_HI:`BPW_PSS_AC_LO];
    assign pair_bd_shutdown_state = auto_shutdown_config[`BPW_PSS_BD_HI:`BPW_PSS_BD_LO];
    assign full_mode = (mode == MODE_FULL_FWD) || (mode == MODE_FULL_REV);
    assign wr_as = i_reg.wr && (i_reg.addr == `BPW_OFF_AS);

    // two-stage synchroniser for comparators and fault pin
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            src_meta_r <= 3'h0;
            src_sync_r <= 3'h0;
        end else begin
            src_meta_r <= {i_fault_input_pin, i_cmp2, i_cmp1};
            src_sync_r <= src_meta_r;
        end
    end

    // select bit n enables source n, so 000 selects nothing
    assign cause = |(shutdown_source_select & src_sync_r);

    // instruction-cycle enable from the core clock
    assign instr_en = (tcy_cnt_r == 2'(TCY_CLKS - 1));

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            tcy_cnt_r <= 2'h0;
        end else if (instr_en) begin
            tcy_cnt_r <= 2'h0;
        end else begin
            tcy_cnt_r <= tcy_cnt_r + 2'h1;
        end
    end

    // prescale length; both upper codes give 16
    always_comb begin
        if (period_timer_prescale_sel == `BPW_PRESC_SEL_1) begin
            presc_len = `BPW_PRESC_1;
        end else if (period_timer_prescale_sel == `BPW_PRESC_SEL_4) begin
            presc_len = `BPW_PRESC_4;
        end else begin
            presc_len = `BPW_PRESC_16;
        end
    end

    // timer increment pulse, one every prescale instruction cycles
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pre_cnt_r <= 5'h00;
            timer_inc_r <= 1'b0;
        end else begin
            timer_inc_r <= 1'b0;
            if (instr_en) begin
                if (pre_cnt_r >= presc_len - 5'h01) begin
                    pre_cnt_r <= 5'h00;
                    timer_inc_r <= 1'b1;
                end else begin
                    pre_cnt_r <= pre_cnt_r + 5'h01;
                end
            end
        end
    end

    // the increment seen while the timer equals its limit clears it
    assign boundary = timer_inc_r && i_timer_match;

    // match holds for exactly one prescaled increment before the boundary
    assign lead = full_mode && i_timer_match && (bridge_direction_bit != dir_cur_r);

    // direction is only taken over at a period boundary
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            dir_cur_r <= 1'b0;
        end else if (boundary) begin
            dir_cur_r <= bridge_direction_bit;
        end
    end

    // run permission is sampled per period, so a flag at the start costs the period
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            run_r <= 1'b0;
        end else if (shutdown_status_bit || cause) begin
            run_r <= 1'b0;
        end else if (boundary) begin
            run_r <= 1'b1;
        end
    end

    // a raw cause shuts down at once, not waiting for the flag flop
    assign hold = shutdown_status_bit || cause || !run_r;

    // dead-band: delay rising edges only, falling edges pass straight
    assign db_target = {~i_pwm_mod, i_pwm_mod};

    for (genvar gi = 0; gi < 2; gi++) begin : g_db
        assign db_ok[gi] = db_target[gi] && (db_cnt_r[gi] >= dead_delay_count);

        always_ff @(posedge i_core_clk) begin
            if (i_rst || !db_target[gi]) begin
                db_cnt_r[gi] <= 7'h00;
            end else if (instr_en && (db_cnt_r[gi] < dead_delay_count)) begin
                db_cnt_r[gi] <= db_cnt_r[gi] + 7'h01;
            end
        end
    end

    // output steering
    always_comb begin
        out_nxt = 4'h0;
        oe_nxt = 4'hF;
        if (hold) begin
            // shutdown states per pin pair: 00 low, 01 high, 1x released
            out_nxt[OUT_A] = pair_ac_shutdown_state[0];
            out_nxt[OUT_C] = pair_ac_shutdown_state[0];
            oe_nxt[OUT_A] = !pair_ac_shutdown_state[1];
            oe_nxt[OUT_C] = !pair_ac_shutdown_state[1];
            out_nxt[OUT_B] = pair_bd_shutdown_state[0];
            out_nxt[OUT_D] = pair_bd_shutdown_state[0];
            oe_nxt[OUT_B] = !pair_bd_shutdown_state[1];
            oe_nxt[OUT_D] = !pair_bd_shutdown_state[1];
        end else if (lead) begin
            // unmodulated pair already in the new direction, modulated off
            out_nxt[OUT_A] = !bridge_direction_bit;
            out_nxt[OUT_C] = bridge_direction_bit;
        end else begin
            case (mode)
                MODE_SINGLE: begin
                    out_nxt[OUT_A] = i_pwm_mod;
                end
                MODE_HALF: begin
                    out_nxt[OUT_A] = db_ok[0];
                    out_nxt[OUT_B] = db_ok[1];
                end
                default: begin
                    // no dead-band here: raw PWM goes to the modulated pin
                    if (!dir_cur_r) begin
                        out_nxt[OUT_A] = 1'b1;
                        out_nxt[OUT_D] = i_pwm_mod;
                    end else begin
                        out_nxt[OUT_C] = 1'b1;
                        out_nxt[OUT_B] = i_pwm_mod;
                    end
                end
            endcase
        end
    end

    // outputs come straight from flops
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            out_r <= 4'h0;
            oe_r <= 4'h0;
        end else begin
            out_r <= out_nxt;
            oe_r <= oe_nxt;
        end
    end

    // shutdown flag: a set always beats a clear in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            shutdown_flag_r <= 1'b0;
        end else if (cause || (wr_as && i_reg.wdata[`BPW_ASE_BIT])) begin
            shutdown_flag_r <= 1'b1;
        end else if (wr_as || auto_restart_enable) begin
            // cause is absent here, so writes during a cause never land
            shutdown_flag_r <= 1'b0;
        end
    end

    // plain configuration writes
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            dead_band_restart_ctrl_r <= `BPW_DEL_RST;
            as_cfg_r <= 7'(`BPW_AS_RST);
            ctrl_r <= `BPW_CTRL_RST;
        end else if (i_reg.wr) begin
            if (i_reg.addr == `BPW_OFF_DEL) begin
                dead_band_restart_ctrl_r <= i_reg.wdata;
            end else if (i_reg.addr == `BPW_OFF_AS) begin
                as_cfg_r <= i_reg.wdata[`BPW_SRC_HI:0];
            end else if (i_reg.addr == `BPW_OFF_CTRL) begin
                ctrl_r <= {4'h0, i_reg.wdata[`BPW_PRESC_HI:0]};
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !i_reg.rd) begin
            rd_data_r <= 8'h00;
        end else if (i_reg.addr == `BPW_OFF_DEL) begin
            rd_data_r <= dead_band_restart_ctrl_r;
        end else if (i_reg.addr == `BPW_OFF_AS) begin
            rd_data_r <= auto_shutdown_config;
        end else if (i_reg.addr == `BPW_OFF_CTRL) begin
            rd_data_r <= ctrl_r;
        end else if (i_reg.addr == `BPW_OFF_STAT) begin
            rd_data_r <= {4'h0, lead, cause, run_r, dir_cur_r};
        end else begin
            rd_data_r <= 8'h00;
        end
    end

    assign o_rd_data = rd_data_r;
    assign o_timer_inc = timer_inc_r;
    assign o_bridge_out = out_r;
    assign o_bridge_oe = oe_r;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    property p_fwd_steer;
        !hold && !lead && mode == MODE_FULL_FWD && !dir_cur_r
            |=> o_bridge_out == {$past(i_pwm_mod), 3'h1};
    endproperty
    a_fwd_steer: assert property (p_fwd_steer)
        else $error("forward steering wrong");

    property p_rev_steer;
        !hold && !lead && mode == MODE_FULL_REV && dir_cur_r
            |=> o_bridge_out == {2'h1, $past(i_pwm_mod), 1'b0};
    endproperty
    a_rev_steer: assert property (p_rev_steer)
        else $error("reverse steering wrong");

    property p_dir_at_boundary;
        $changed(dir_cur_r) |-> $past(boundary);
    endproperty
    a_dir_at_boundary: assert property (p_dir_at_boundary)
        else $error("direction changed off a period boundary");

    property p_lead_quiet;
        lead && !hold |=> !o_bridge_out[OUT_B] && !o_bridge_out[OUT_D]
            && o_bridge_out[OUT_C] == $past(bridge_direction_bit);
    endproperty
    a_lead_quiet: assert property (p_lead_quiet)
        else $error("lead interval outputs wrong");

    property p_cause_sets;
        cause |=> shutdown_status_bit ##0 o_bridge_oe[OUT_A] == !$past(pair_ac_shutdown_state[1]);
    endproperty
    a_cause_sets: assert property (p_cause_sets)
        else $error("shutdown cause did not set flag or pin state");

    property p_write_ignored;
        cause && wr_as && !i_reg.wdata[`BPW_ASE_BIT] |=> shutdown_status_bit;
    endproperty
    a_write_ignored: assert property (p_write_ignored)
        else $error("flag cleared while cause active");

    property p_restart;
        auto_restart_enable && shutdown_status_bit && !cause && !wr_as |=> !shutdown_status_bit;
    endproperty
    a_restart: assert property (p_restart)
        else $error("auto restart did not clear flag");

    property p_sticky;
        !auto_restart_enable && shutdown_status_bit && !wr_as |=> shutdown_status_bit;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag cleared without software");

    property p_src_off;
        shutdown_source_select == 3'h0 && !shutdown_status_bit && !wr_as |=> !shutdown_status_bit;
    endproperty
    a_src_off: assert property (p_src_off)
        else $error("flag set with no source selected");

    property p_half_fall;
        !hold && mode == MODE_HALF && !i_pwm_mod |=> !o_bridge_out[OUT_A];
    endproperty
    a_half_fall: assert property (p_half_fall)
        else $error("half-bridge falling edge delayed");

endmodule // bridge_pwm_steering_shutdown

// >>> testbench/period_timer_model.sv
// Purpose: period timer and duty comparator standing beside the bridge stage
// Assumes: one clock, synchronous active-high reset
// Notes: behavioural; limit and duty are set by the bench
module period_timer_model (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_timer_inc,
    input wire logic [7:0] i_limit,
    input wire logic [7:0] i_duty,
    output logic o_timer_match,
    output logic o_pwm_mod
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] count_r;
    // the increment after a match clears the count and opens a period
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            count_r <= 8'h00;
        end else if (i_timer_inc) begin
            count_r <= o_timer_match ? 8'h00 : count_r + 8'h01;
        end
    end
    // both levels come from one register, so no glitches reach the stage
    assign o_timer_match = (count_r == i_limit);
    assign o_pwm_mod = (count_r < i_duty);
endmodule // period_timer_model

// >>> testbench/test_bridge_pwm_steering_shutdown.sv
// Purpose: self-checking bench for the bridge steering and shutdown stage
// Assumes: 50 MHz clock, instruction cycle of four clocks
// Notes: period of 16 timer counts at duty 8 keeps each run short
`include "bridge_pwm_map.svh"
module test_bridge_pwm_steering_shutdown;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    bridge_pwm_pkg::reg_req_t reg_req = '0;
    logic [7:0] rd_data;
    logic pwm, tmatch, tinc, pwm_q, match_q;
    logic cmp1 = 1'b0;
    logic cmp2 = 1'b0;
    logic fault = 1'b0;
    logic [3:0] bout, boe;
    int miscompares = 0;
    int n_tests = 0;

    // clock and the previous-cycle view of the timer side
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) pwm_q <= pwm;
    always @(posedge core_clk) match_q <= tmatch;

    bridge_pwm_steering_shutdown #(.TCY_CLKS(`BPW_TCY_CLKS_DEF)) dut_u (
        .i_core_clk(core_clk), .i_rst(rst), .i_reg(reg_req), .o_rd_data(rd_data),
        .i_pwm_mod(pwm), .i_timer_match(tmatch), .o_timer_inc(tinc),
        .i_cmp1(cmp1), .i_cmp2(cmp2), .i_fault_input_pin(fault),
        .o_bridge_out(bout), .o_bridge_oe(boe));

    // moderate duty keeps direction reversal safe
    period_timer_model model_u (
        .i_core_clk(core_clk), .i_rst(rst), .i_timer_inc(tinc), .i_limit(8'h0F),
        .i_duty(8'h08), .o_timer_match(tmatch), .o_pwm_mod(pwm));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // one-cycle strobes; read data is taken in the following cycle only
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        reg_req <= '0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        reg_req <= '0;
        @(negedge core_clk);
        d = rd_data;
    endtask

    // returns in the cycle that ends a period
    task automatic wait_bnd();
        int k;
        for (k = 0; k < 3000; k++) begin
            @(negedge core_clk);
            if (tinc === 1'b1 && tmatch === 1'b1) break;
        end
        // no boundary at all is a fault, not a silent return
        if (k == 3000) miscompares++;
    endtask

    task automatic wait_inc(output int n);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (tinc !== 1'b1 && n < 2000);
    endtask

    task automatic delay_to(input int b, input logic lvl, output int n);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (bout[b] !== lvl && n < 200);
    endtask

    // steady pattern check, skipping cycles around the period end
    task automatic steer(input bridge_pwm_pkg::out_mode_t m, input int cyc);
        repeat (cyc) begin
            @(negedge core_clk);
            if (tmatch === 1'b0 && match_q === 1'b0) begin
                check(8'(boe), 8'h0F);
                if (m == bridge_pwm_pkg::MODE_FULL_FWD) check(8'(bout), {4'h0, pwm_q, 3'h1});
                else check(8'(bout), {6'h01, pwm_q, 1'b0});
            end
        end
    endtask

    task automatic t_regs();
        logic [3:0] addrs [4] = '{`BPW_OFF_DEL, `BPW_OFF_AS, `BPW_OFF_CTRL, 4'hF};
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            reg_rd(addrs[i], v);
            check(v, 8'h00);
        end
        reg_wr(`BPW_OFF_DEL, 8'hFF);
        reg_rd(`BPW_OFF_DEL, v);
        check(v, 8'hFF);
        reg_wr(`BPW_OFF_DEL, 8'h00);
        reg_wr(`BPW_OFF_CTRL, 8'hFF);
        reg_rd(`BPW_OFF_CTRL, v);
        check(v, 8'h0F);
    endtask

    task automatic t_prescale();
        int gap [4] = '{4, 16, 64, 64};
        int n;
        for (int s = 0; s < 4; s++) begin
            reg_wr(`BPW_OFF_CTRL, 8'(s << 2) | 8'h01);
            wait_inc(n);
            wait_inc(n);
            wait_inc(n);
            check(8'(n), 8'(gap[s]));
        end
    endtask

    task automatic t_steer();
        logic [7:0] v;
        reg_wr(`BPW_OFF_DEL, 8'h03);
        reg_wr(`BPW_OFF_CTRL, 8'h01);
        wait_bnd();
        wait_bnd();
        steer(bridge_pwm_pkg::MODE_FULL_FWD, 40);
        wait_bnd();
        reg_wr(`BPW_OFF_CTRL, 8'h03);
        steer(bridge_pwm_pkg::MODE_FULL_FWD, 20);
        do @(negedge core_clk); while (tmatch !== 1'b1);
        @(negedge core_clk);
        check(8'(bout), 8'h04);
        wait_bnd();
        wait_bnd();
        steer(bridge_pwm_pkg::MODE_FULL_REV, 40);
        // status: reverse taken over, running, no cause, no lead
        reg_rd(`BPW_OFF_STAT, v);
        check(v, 8'h03);
    endtask

    // delay 3 is twelve clocks, one more for the output register, +-4
    task automatic t_half();
        int n;
        reg_wr(`BPW_OFF_CTRL, 8'h02);
        wait_bnd();
        wait_bnd();
        do @(negedge core_clk); while (!(pwm === 1'b1 && pwm_q === 1'b0));
        delay_to(0, 1'b1, n);
        check(8'(n >= 9 && n <= 17), 8'h01);
        do @(negedge core_clk); while (!(pwm === 1'b0 && pwm_q === 1'b1));
        delay_to(0, 1'b0, n);
        check(8'(n), 8'h01);
        delay_to(1, 1'b1, n);
        check(8'(n + 1 >= 9 && n + 1 <= 17), 8'h01);
    endtask

    // every select code against every single source, restart enabled
    task automatic t_sources();
        logic [7:0] v;
        reg_wr(`BPW_OFF_DEL, 8'h80);
        reg_wr(`BPW_OFF_CTRL, 8'h01);
        for (int sel = 0; sel < 8; sel++) begin
            for (int s = 0; s < 3; s++) begin
                reg_wr(`BPW_OFF_AS, 8'(sel << 4) | 8'h04);
                @(posedge core_clk);
                {fault, cmp2, cmp1} <= 3'(1 << s);
                repeat (5) @(negedge core_clk);
                reg_rd(`BPW_OFF_AS, v);
                check(8'(v[7]), 8'(sel >> s) & 8'h01);
                if (v[7] === 1'b1) check({boe, bout}, 8'hF5);
                @(posedge core_clk);
                {fault, cmp2, cmp1} <= 3'h0;
                repeat (5) @(negedge core_clk);
                reg_rd(`BPW_OFF_AS, v);
                check(8'(v[7]), 8'h00);
            end
        end
    endtask

    task automatic t_latch();
        logic [7:0] v;
        reg_wr(`BPW_OFF_DEL, 8'h00);
        reg_wr(`BPW_OFF_AS, 8'h14);
        @(posedge core_clk);
        cmp1 <= 1'b1;
        repeat (5) @(negedge core_clk);
        reg_wr(`BPW_OFF_AS, 8'h14);
        reg_rd(`BPW_OFF_AS, v);
        check(v, 8'h94);
        @(posedge core_clk);
        cmp1 <= 1'b0;
        repeat (8) @(negedge core_clk);
        reg_rd(`BPW_OFF_AS, v);
        check(v, 8'h94);
        reg_wr(`BPW_OFF_AS, 8'h14);
        reg_rd(`BPW_OFF_AS, v);
        check(v, 8'h14);
    endtask

    task automatic t_force();
        logic [7:0] v;
        wait_bnd();
        reg_wr(`BPW_OFF_AS, 8'h8B);
        repeat (2) @(negedge core_clk);
        check(8'(boe), 8'h00);
        reg_rd(`BPW_OFF_AS, v);
        check(v, 8'h8B);
        reg_wr(`BPW_OFF_AS, 8'h0B);
        repeat (2) @(negedge core_clk);
        check(8'(boe), 8'h00);
        wait_bnd();
        wait_bnd();
        repeat (2) @(negedge core_clk);
        check(8'(boe), 8'h0F);
    endtask

    // main sequence after a 20-cycle reset
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        $display("register test done");
        t_prescale();
        $display("prescale test done");
        t_steer();
        $display("steering test done");
        t_half();
        $display("half-bridge test done");
        t_sources();
        $display("source select test done");
        t_latch();
        $display("latched shutdown test done");
        t_force();
        $display("forced shutdown test done");
        print_verdict();
    end

    // the sequence needs about 2000 cycles; 20000 means a hang
    initial begin
        #400000;
        miscompares++;
        print_verdict();
    end
endmodule // test_bridge_pwm_steering_shutdown
